// ---- identity_regs.svh ----
// Register addresses, pages and reset values of the identity bank
`ifndef IDENTITY_REGS_SVH
`define IDENTITY_REGS_SVH
`define ADDR_DERIVATIVE_CODE 8'hAB
`define ADDR_SILICON_REVISION 8'hAC
`define ADDR_SERIAL_BYTE0 8'hAB
`define ADDR_SERIAL_BYTE1 8'hAC
`define ADDR_SERIAL_BYTE2 8'hAD
`define ADDR_SERIAL_BYTE3 8'hAE
`define ADDR_PAGE_SELECT 8'hA7
`define PAGE_ZERO 8'h00
`define PAGE_F 8'h0F
`define PAGE_SELECT_RESET 8'h00
`define UNMAPPED_READ 8'h00
`endif

// ---- identity_pkg.sv ----
// Types shared by the identity register bank
package identity_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0]
    {
        SEL_NONE  = 2'b00,
        SEL_FIXED = 2'b01,
        SEL_SER   = 2'b11,
        SEL_PAGE  = 2'b10
    } read_sel_t;
endpackage

// ---- serial_store.sv ----
// Four byte serial number store, writable as general purpose registers
`timescale 1ns/1ps
`include "identity_regs.svh"
module serial_store
    import identity_pkg::*;
#(
    parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_index,
    input  wire byte_t      wr_data,
    input  wire logic [1:0] rd_index,
    output byte_t           rd_data
);
    byte_t serial_byte [4];
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_byte
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    serial_byte[g] <= SERIAL_NUMBER[8*g +: 8];
                else if (wr_en && wr_index == 2'(g))
                    serial_byte[g] <= wr_data;
            end
        end
    endgenerate
    assign rd_data = serial_byte[rd_index];
endmodule // serial_store

// ---- device_identity_registers.sv ----
// Device identity register bank with page select and serial number
//
// Contract
// - Page zero address AB reads a fixed derivative code.
// - Page zero address AC reads a fixed silicon revision code.
// - A 32-bit production serial number is readable as four bytes.
// - Page F address AE reads serial byte 3, the top byte.
// - Page F address AD reads serial byte 2.
// - Page F address AC reads serial byte 1, not the revision.
// - Page F address AB reads serial byte 0, not the derivative.
// - Serial bytes may be written and used as general registers.
// - Pages zero and F exist and the page select picks the register.
`timescale 1ns/1ps
`include "identity_regs.svh"
module device_identity_registers
    import identity_pkg::*;
#(
    // Arbitrary neutral values
    parameter byte_t       DERIVATIVE_CODE  = 8'h5A,
    parameter byte_t       SILICON_REVISION = 8'h3C,
    parameter logic [31:0] SERIAL_NUMBER    = 32'h1234_5678
)
(
    input  wire logic  clk_sys,
    input  wire logic  rst,
    input  wire byte_t reg_addr,
    input  wire logic  reg_wr,
    input  wire logic  reg_rd,
    input  wire byte_t reg_wdata,
    output byte_t      reg_rdata,
    output logic       reg_hit,
    output byte_t      register_page_select
);
    byte_t     next_rdata;
    read_sel_t sel;
    byte_t     fixed_val;
    byte_t     serial_rd;
    logic      page_f;
    logic      page_zero;
    logic      hit_page;
    logic      hit_ser;
    logic      hit_fixed;
    logic [1:0] ser_index;

    assign page_f    = register_page_select == `PAGE_F;
    assign page_zero = register_page_select == `PAGE_ZERO;
    assign hit_page  = reg_addr == `ADDR_PAGE_SELECT;

    assign hit_ser = page_f && (reg_addr == `ADDR_SERIAL_BYTE0 ||
                                reg_addr == `ADDR_SERIAL_BYTE1 ||
                                reg_addr == `ADDR_SERIAL_BYTE2 ||
                                reg_addr == `ADDR_SERIAL_BYTE3);
    assign ser_index = 2'(reg_addr - `ADDR_SERIAL_BYTE0);

    assign hit_fixed = page_zero && (reg_addr == `ADDR_DERIVATIVE_CODE ||
                                     reg_addr == `ADDR_SILICON_REVISION);
    assign fixed_val = (reg_addr == `ADDR_DERIVATIVE_CODE)
                     ? DERIVATIVE_CODE : SILICON_REVISION;

    assign sel = hit_page  ? SEL_PAGE  :
                 hit_ser   ? SEL_SER   :
                 hit_fixed ? SEL_FIXED : SEL_NONE;
    assign reg_hit = sel != SEL_NONE;

    always_comb
    begin
        case (sel)
            SEL_PAGE:  next_rdata = register_page_select;
            SEL_SER:   next_rdata = serial_rd;
            SEL_FIXED: next_rdata = fixed_val;
            default:   next_rdata = `UNMAPPED_READ;
        endcase
    end

    serial_store #(
        .SERIAL_NUMBER (SERIAL_NUMBER)
    ) u_serial (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_en    (reg_wr && hit_ser),
        .wr_index (ser_index),
        .wr_data  (reg_wdata),
        .rd_index (ser_index),
        .rd_data  (serial_rd)
    );

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            register_page_select <= `PAGE_SELECT_RESET;
        else if (reg_wr && hit_page)
            register_page_select <= reg_wdata;
    end

    // Fixed codes never stored, so writes drop
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata <= `UNMAPPED_READ;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // Reference copy of the serial bytes with its own address decode, so
    // a slip in the shared datapath decode cannot hide behind itself
    localparam byte_t SER_ADDR [4] = '{`ADDR_SERIAL_BYTE0,
                                       `ADDR_SERIAL_BYTE1,
                                       `ADDR_SERIAL_BYTE2,
                                       `ADDR_SERIAL_BYTE3};
    byte_t           model_byte [4];
    wire logic [3:0] model_wr;
    wire logic [3:0] model_rd;

    genvar m;
    generate
        for (m = 0; m < 4; m++)
        begin : g_model
            assign model_wr[m] = reg_wr && page_f
                                 && reg_addr == SER_ADDR[m];
            assign model_rd[m] = reg_rd && page_f
                                 && reg_addr == SER_ADDR[m];

            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    model_byte[m] <= SERIAL_NUMBER[8*m +: 8];
                else if (model_wr[m])
                    model_byte[m] <= reg_wdata;
            end

            sequence byte_write_s;
                model_wr[m] && !reg_rd;
            endsequence
            sequence byte_read_s;
                model_rd[m] && !reg_wr;
            endsequence

            chk_serial_value: assert property (
                @(posedge clk_sys) disable iff (rst)
                model_rd[m] |=> reg_rdata == $past(model_byte[m]))
                else $error("serial byte read wrong");

            chk_serial_hit: assert property (
                @(posedge clk_sys) disable iff (rst)
                model_rd[m] |-> reg_hit)
                else $error("serial address not mapped");

            chk_byte_rewrite: assert property (
                @(posedge clk_sys) disable iff (rst)
                byte_write_s ##1 byte_read_s
                |=> reg_rdata == $past(reg_wdata, 2))
                else $error("serial byte write lost");
        end
    endgenerate

    // Named access patterns used by the checks below
    sequence deriv_read_s;
        reg_rd && page_zero && reg_addr == `ADDR_DERIVATIVE_CODE;
    endsequence
    sequence deriv_write_s;
        reg_wr && page_zero && reg_addr == `ADDR_DERIVATIVE_CODE;
    endsequence
    sequence rev_read_s;
        reg_rd && page_zero && reg_addr == `ADDR_SILICON_REVISION;
    endsequence
    sequence rev_write_s;
        reg_wr && page_zero && reg_addr == `ADDR_SILICON_REVISION;
    endsequence
    sequence byte1_read_s;
        reg_rd && page_f && reg_addr == `ADDR_SERIAL_BYTE1;
    endsequence
    sequence ser_write_s;
        reg_wr && !reg_rd && page_f && reg_addr == `ADDR_SERIAL_BYTE3;
    endsequence
    sequence ser_read_s;
        reg_rd && !reg_wr && page_f && reg_addr == `ADDR_SERIAL_BYTE3;
    endsequence
    sequence page_write_s;
        reg_wr && hit_page;
    endsequence
    sequence unmapped_read_s;
        reg_rd && !reg_hit;
    endsequence

    chk_derivative_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        deriv_read_s |=> reg_rdata == DERIVATIVE_CODE)
        else $error("derivative code read wrong");

    chk_deriv_hit: assert property (
        @(posedge clk_sys) disable iff (rst)
        deriv_read_s |-> reg_hit)
        else $error("derivative address not mapped");

    chk_revision_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        rev_read_s |=> reg_rdata == SILICON_REVISION)
        else $error("revision code read wrong");

    chk_rev_hit: assert property (
        @(posedge clk_sys) disable iff (rst)
        rev_read_s |-> reg_hit)
        else $error("revision address not mapped");

    chk_page_f_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        byte1_read_s |=> reg_rdata == $past(serial_rd))
        else $error("page F read wrong");

    chk_serial_rewrite: assert property (
        @(posedge clk_sys) disable iff (rst)
        ser_write_s ##1 ser_read_s
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("serial byte not writable");

    chk_fixed_ignore: assert property (
        @(posedge clk_sys) disable iff (rst)
        deriv_write_s ##1 deriv_read_s
        |=> reg_rdata == DERIVATIVE_CODE)
        else $error("fixed code changed by write");

    chk_revision_ignore: assert property (
        @(posedge clk_sys) disable iff (rst)
        rev_write_s ##1 rev_read_s
        |=> reg_rdata == SILICON_REVISION)
        else $error("revision code changed by write");

    chk_page_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        page_write_s |=> register_page_select == $past(reg_wdata))
        else $error("page select not updated");

    // Page only moves on its write
    chk_page_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(reg_wr && hit_page) |=> $stable(register_page_select))
        else $error("page select moved");

    chk_page_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_rd && !reg_wr && hit_page
        |=> reg_rdata == $past(register_page_select))
        else $error("page select read wrong");

    // Read beside write sees old value
    chk_read_before_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        reg_rd && reg_wr && hit_page
        |=> reg_rdata == $past(register_page_select))
        else $error("same cycle read saw new page");

    chk_unmapped_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        unmapped_read_s |=> reg_rdata == `UNMAPPED_READ)
        else $error("unmapped read not zero");

    chk_reset_values: assert property (
        @(posedge clk_sys)
        rst |=> register_page_select == `PAGE_SELECT_RESET
        && reg_rdata == `UNMAPPED_READ)
        else $error("reset values wrong");

    chk_rdata_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");

    chk_zero_no_serial: assert property (
        @(posedge clk_sys) disable iff (rst)
        page_zero && (reg_addr == `ADDR_SERIAL_BYTE2 ||
                      reg_addr == `ADDR_SERIAL_BYTE3) |-> !reg_hit)
        else $error("serial byte seen on page zero");

    chk_stray_page: assert property (
        @(posedge clk_sys) disable iff (rst)
        !page_zero && !page_f && !hit_page |-> !reg_hit)
        else $error("register mapped on unknown page");

    chk_shared_hit: assert property (
        @(posedge clk_sys) disable iff (rst)
        (page_zero || page_f) && (reg_addr == `ADDR_SERIAL_BYTE0 ||
                                  reg_addr == `ADDR_SERIAL_BYTE1) |-> reg_hit)
        else $error("shared address not mapped");
endmodule // device_identity_registers

// ---- tb.sv ----
// Self-checking bench for the device identity register bank
`timescale 1ns/1ps
`include "identity_regs.svh"
module tb
    import identity_pkg::*;
;
    localparam logic [31:0] SERIAL = 32'h8765_4321;
    // Arbitrary neutral identity values
    localparam byte_t       DERIV  = 8'h6B;
    localparam byte_t       REV    = 8'h2E;
    logic        clk_sys   = 1'b0;
    logic        rst       = 1'b1;
    byte_t       reg_addr  = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    byte_t       reg_wdata = 8'h00;
    byte_t       reg_rdata;
    logic        reg_hit;
    byte_t       register_page_select;
    int          fails     = 0;
    int          checked   = 0;
    int          cycles    = 0;

    device_identity_registers #(
        .DERIVATIVE_CODE (DERIV),
        .SILICON_REVISION(REV),
        .SERIAL_NUMBER   (SERIAL)
    ) i_device_identity_registers (
        .clk_sys             (clk_sys),
        .rst                 (rst),
        .reg_addr            (reg_addr),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_wdata           (reg_wdata),
        .reg_rdata           (reg_rdata),
        .reg_hit             (reg_hit),
        .register_page_select(register_page_select)
    );

    always #5 clk_sys = ~clk_sys;

    task automatic report_and_stop();
        $display("Counts: checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Whole run needs about 70 cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles >= 400)
        begin
            fails++;
            report_and_stop();
        end
    end

    task automatic check_byte(input byte_t got, input byte_t exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
    endtask

    // Write then read in the very next cycle
    task automatic wr_rd(input byte_t a, input byte_t d, input byte_t exp);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_rd    = 1'b1;
        @(negedge clk_sys);
        reg_rd    = 1'b0;
        check_byte(reg_rdata, exp);
    endtask

    // Read and write in one cycle: the read sees the old value
    task automatic rd_wr(input byte_t a, input byte_t d, input byte_t exp);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        reg_rd    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        check_byte(reg_rdata, exp);
    endtask

    // Hit is combinational, so it is sampled while the strobe stands
    task automatic expect_rd(input byte_t a, input byte_t exp, input logic hit);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd   = 1'b1;
        #1 check_byte({7'h00, reg_hit}, {7'h00, hit});
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        check_byte(reg_rdata, exp);
    endtask

    initial
    begin
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        check_byte(register_page_select, `PAGE_ZERO);
        check_byte(reg_rdata, `UNMAPPED_READ);
        expect_rd(`ADDR_DERIVATIVE_CODE, DERIV, 1'b1);
        expect_rd(`ADDR_SILICON_REVISION, REV, 1'b1);
        wr(`ADDR_DERIVATIVE_CODE, 8'hFF);
        wr(`ADDR_SILICON_REVISION, 8'h00);
        check_byte(reg_rdata, REV);
        wr_rd(`ADDR_DERIVATIVE_CODE, 8'hFF, DERIV);
        wr_rd(`ADDR_SILICON_REVISION, 8'h00, REV);
        expect_rd(`ADDR_DERIVATIVE_CODE, DERIV, 1'b1);
        expect_rd(`ADDR_SILICON_REVISION, REV, 1'b1);
        expect_rd(`ADDR_SERIAL_BYTE2, `UNMAPPED_READ, 1'b0);
        wr(`ADDR_PAGE_SELECT, `PAGE_F);
        check_byte(register_page_select, `PAGE_F);
        expect_rd(`ADDR_PAGE_SELECT, `PAGE_F, 1'b1);
        for (int i = 0; i < 4; i++)
            expect_rd(byte_t'(`ADDR_SERIAL_BYTE0 + i), SERIAL[8*i +: 8],
                      1'b1);
        wr(`ADDR_SERIAL_BYTE2, 8'hA5);
        wr(`ADDR_SERIAL_BYTE0, 8'hC3);
        expect_rd(`ADDR_SERIAL_BYTE2, 8'hA5, 1'b1);
        expect_rd(`ADDR_SERIAL_BYTE3, SERIAL[31:24], 1'b1);
        wr_rd(`ADDR_SERIAL_BYTE3, 8'h96, 8'h96);
        wr(8'h80, 8'h77);
        expect_rd(8'h80, `UNMAPPED_READ, 1'b0);
        wr(`ADDR_PAGE_SELECT, 8'h05);
        expect_rd(`ADDR_SERIAL_BYTE0, `UNMAPPED_READ, 1'b0);
        wr(`ADDR_PAGE_SELECT, `PAGE_ZERO);
        expect_rd(`ADDR_DERIVATIVE_CODE, DERIV, 1'b1);
        // Second reset restores the production serial number
        @(negedge clk_sys);
        rst = 1'b1;
        wr(`ADDR_PAGE_SELECT, `PAGE_F);
        rst = 1'b0;
        check_byte(register_page_select, `PAGE_ZERO);
        check_byte(reg_rdata, `UNMAPPED_READ);
        rd_wr(`ADDR_PAGE_SELECT, `PAGE_F, `PAGE_ZERO);
        check_byte(register_page_select, `PAGE_F);
        wr(`ADDR_PAGE_SELECT, `PAGE_F);
        expect_rd(`ADDR_SERIAL_BYTE2, SERIAL[23:16], 1'b1);
        expect_rd(`ADDR_SERIAL_BYTE0, SERIAL[7:0], 1'b1);
        report_and_stop();
    end
endmodule // tb
